// >>> uiae_evt_latch.sv
// uiae_evt_latch: sticky event flags, set by pulses, cleared by writing one.
// assumes event pulses synchronous to ref_clk.
`timescale 1ns/100ps
module uiae_evt_latch (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire uiae_pkg::uiae_events_t set_pulse,
  input wire uiae_pkg::uiae_events_t clear_ones,
  output uiae_pkg::uiae_events_t flags
);
  import uiae_pkg::*;

  uiae_events_t flags_ff;
  uiae_events_t nxt_flags;

  // set wins over a clear in the same cycle
  assign nxt_flags = (flags_ff & ~clear_ones) | set_pulse;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      flags_ff <= '0;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  assign flags = flags_ff;

  AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (!resetn)
    (set_pulse.suspend |=> flags.suspend))
    else $error("suspend flag lost on set");

endmodule // uiae_evt_latch

// >>> uiae_host_model.sv
// uiae_host_model: core-side avalon-mm master for the register slice.
// assumes a free-running ref_clk and one request at a time.
`timescale 1ns/100ps
module uiae_host_model (
  input wire logic ref_clk,
  output logic [7:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest
);
  initial begin
    avs_address = 8'h_00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h_0000_0000;
    avs_byteenable = 4'h_0;
  end

  // ---------------------------------------------------------------
  // one bus cycle
  // ---------------------------------------------------------------
  // waitrequest and read data are taken at the rising edge itself,
  // before that edge's own updates land; the bench watchdog ends a hang
  task automatic xfer(input logic [7:0] a, input logic wr,
                      input logic [7:0] d, input logic [3:0] be,
                      output logic [31:0] q);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {24'h_00_0000, d};
    avs_byteenable <= be;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule // uiae_host_model

// >>> uiae_pkg.sv
// uiae_pkg: constants and carrier types for the usb interrupt enable,
// function address and endpoint select register slice.
// assumes a 32-bit avalon-mm slave with byte addresses below 0x400.
package uiae_pkg;

  // ---------------------------------------------------------------
  // register indices (printed offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] UIAE_IDX_IRQ_ENABLE = 8'h_be;
  localparam logic [7:0] UIAE_IDX_FUNC_ADDR = 8'h_c6;
  localparam logic [7:0] UIAE_IDX_EP_SELECT = 8'h_c7;
  localparam logic [7:0] UIAE_IDX_EVT_STATUS = 8'h_c0;
  localparam logic [7:0] UIAE_IDX_GLOBAL_CTRL = 8'h_c1;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int UIAE_BIT_WAKE = 5;
  localparam int UIAE_BIT_EOR = 4;
  localparam int UIAE_BIT_SOF = 3;
  localparam int UIAE_BIT_SUSP = 0;
  localparam int UIAE_BIT_FILTER = 7;
  localparam int UIAE_BIT_ADDR_VALID = 0;

  // ---------------------------------------------------------------
  // masks and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] UIAE_IRQ_EN_MASK = 8'h_39;
  localparam logic [7:0] UIAE_EP_SEL_MASK = 8'h_0f;
  localparam logic [7:0] UIAE_CTRL_MASK = 8'h_01;
  localparam logic [7:0] UIAE_RST_IRQ_ENABLE = 8'h_10;
  localparam logic [7:0] UIAE_RST_FUNC_ADDR = 8'h_00;
  localparam logic [7:0] UIAE_RST_EP_SELECT = 8'h_00;
  localparam logic [7:0] UIAE_RST_GLOBAL_CTRL = 8'h_00;
  localparam logic [6:0] UIAE_DEFAULT_ADDR = 7'h_00;
  localparam logic [31:0] UIAE_UNMAPPED_DATA = 32'h_0000_0000;

  // ---------------------------------------------------------------
  // carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic wake_cpu;
    logic end_of_reset;
    logic frame_start;
    logic suspend;
  } uiae_events_t;

  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } uiae_avs_req_t;

endpackage

// >>> uiae_regs.sv
// uiae_regs: usb interrupt enable, function address, endpoint select.
// assumes an avalon-mm master on ref_clk; usb events arrive as one-cycle
// pulses synchronous to ref_clk from the serial engine.
`timescale 1ns/100ps
module uiae_regs (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire uiae_pkg::uiae_events_t usb_event_pulse,
  input wire logic usb_bus_reset,
  output logic usb_irq,
  output logic [6:0] active_function_address,
  output logic address_filter_enable,
  output logic [3:0] endpoint_index
);
  import uiae_pkg::*;

  // ---------------------------------------------------------------
  // bus handshake: one wait state, answer on the second edge
  // ---------------------------------------------------------------
  logic ack_ff;
  logic req;
  logic take;
  logic lane0;
  uiae_avs_req_t bus;

  assign bus = '{address: avs_address, read: avs_read, write: avs_write,
                 writedata: avs_writedata, byteenable: avs_byteenable};
  assign req = bus.read | bus.write;
  assign take = req & ack_ff;
  assign avs_waitrequest = req & ~ack_ff;
  assign lane0 = bus.byteenable[0];

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req & ~ack_ff;
    end
  end

  logic wr_take;
  assign wr_take = take & bus.write & lane0;

  // ---------------------------------------------------------------
  // interrupt enable register
  // ---------------------------------------------------------------
  logic [7:0] irq_enable_ff;
  logic [7:0] nxt_irq_enable;

  assign nxt_irq_enable = bus.writedata[7:0] & UIAE_IRQ_EN_MASK;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      irq_enable_ff <= UIAE_RST_IRQ_ENABLE;
    end else if (wr_take && bus.address == UIAE_IDX_IRQ_ENABLE) begin
      irq_enable_ff <= nxt_irq_enable;
    end
  end

  // ---------------------------------------------------------------
  // function address register
  // ---------------------------------------------------------------
  logic [7:0] func_addr_ff;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      func_addr_ff <= UIAE_RST_FUNC_ADDR;
    end else if (usb_bus_reset) begin
      func_addr_ff[6:0] <= UIAE_DEFAULT_ADDR;
      if (wr_take && bus.address == UIAE_IDX_FUNC_ADDR) begin
        func_addr_ff[UIAE_BIT_FILTER] <= bus.writedata[UIAE_BIT_FILTER];
      end
    end else if (wr_take && bus.address == UIAE_IDX_FUNC_ADDR) begin
      func_addr_ff <= bus.writedata[7:0];
    end
  end

  // ---------------------------------------------------------------
  // global control: address-valid flag
  // ---------------------------------------------------------------
  logic [7:0] global_ctrl_ff;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      global_ctrl_ff <= UIAE_RST_GLOBAL_CTRL;
    end else if (usb_bus_reset) begin
      global_ctrl_ff <= UIAE_RST_GLOBAL_CTRL;
    end else if (wr_take && bus.address == UIAE_IDX_GLOBAL_CTRL) begin
      global_ctrl_ff <= bus.writedata[7:0] & UIAE_CTRL_MASK;
    end
  end

  // default address while not yet valid
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      active_function_address <= UIAE_DEFAULT_ADDR;
    end else if (global_ctrl_ff[UIAE_BIT_ADDR_VALID]) begin
      active_function_address <= func_addr_ff[6:0];
    end else begin
      active_function_address <= UIAE_DEFAULT_ADDR;
    end
  end

  assign address_filter_enable = func_addr_ff[UIAE_BIT_FILTER];

  // ---------------------------------------------------------------
  // endpoint select register
  // ---------------------------------------------------------------
  logic [7:0] ep_select_ff;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ep_select_ff <= UIAE_RST_EP_SELECT;
    end else if (wr_take && bus.address == UIAE_IDX_EP_SELECT) begin
      // values above six are not checked; software keeps to 0..6
      ep_select_ff <= bus.writedata[7:0] & UIAE_EP_SEL_MASK;
    end
  end

  assign endpoint_index = ep_select_ff[3:0];

  // ---------------------------------------------------------------
  // event flags and interrupt
  // ---------------------------------------------------------------
  uiae_events_t flags;
  uiae_events_t clear_ones;
  uiae_events_t enables;

  assign clear_ones = (wr_take && bus.address == UIAE_IDX_EVT_STATUS) ?
                      uiae_events_t'{wake_cpu: bus.writedata[UIAE_BIT_WAKE],
                        end_of_reset: bus.writedata[UIAE_BIT_EOR],
                        frame_start: bus.writedata[UIAE_BIT_SOF],
                        suspend: bus.writedata[UIAE_BIT_SUSP]} : '0;

  uiae_evt_latch u_evt_latch (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .set_pulse(usb_event_pulse),
    .clear_ones(clear_ones),
    .flags(flags)
  );

  assign enables = '{wake_cpu: irq_enable_ff[UIAE_BIT_WAKE],
                     end_of_reset: irq_enable_ff[UIAE_BIT_EOR],
                     frame_start: irq_enable_ff[UIAE_BIT_SOF],
                     suspend: irq_enable_ff[UIAE_BIT_SUSP]};

  assign usb_irq = |(flags & enables);

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  logic [7:0] status_view;

  always_comb begin
    status_view = 8'h_00;
    status_view[UIAE_BIT_WAKE] = flags.wake_cpu;
    status_view[UIAE_BIT_EOR] = flags.end_of_reset;
    status_view[UIAE_BIT_SOF] = flags.frame_start;
    status_view[UIAE_BIT_SUSP] = flags.suspend;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= UIAE_UNMAPPED_DATA;
    end else if (bus.read && !ack_ff) begin
      unique case (bus.address)
        UIAE_IDX_IRQ_ENABLE: avs_readdata <= {24'h_0000_00, irq_enable_ff};
        UIAE_IDX_FUNC_ADDR: avs_readdata <= {24'h_0000_00, func_addr_ff};
        UIAE_IDX_EP_SELECT: avs_readdata <= {24'h_0000_00, ep_select_ff};
        UIAE_IDX_EVT_STATUS: avs_readdata <= {24'h_0000_00, status_view};
        UIAE_IDX_GLOBAL_CTRL: avs_readdata <= {24'h_0000_00, global_ctrl_ff};
        default: avs_readdata <= UIAE_UNMAPPED_DATA;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_write_addr_reg;
    wr_take && bus.address == UIAE_IDX_FUNC_ADDR && !usb_bus_reset;
  endsequence

  sequence s_read_ep_select;
    bus.read && !ack_ff && bus.address == UIAE_IDX_EP_SELECT;
  endsequence

  sequence s_req_waiting;
    req && avs_waitrequest;
  endsequence

  AST_RESERVED_IRQ_EN: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (irq_enable_ff & ~UIAE_IRQ_EN_MASK) == 8'h_00)
    else $error("reserved enable bits set");

  AST_WAKE_GATE: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (flags.wake_cpu && irq_enable_ff[UIAE_BIT_WAKE]) |-> usb_irq)
    else $error("wake flag did not interrupt");

  AST_EOR_RESET: assert property (
    @(posedge ref_clk)
    $rose(resetn) |-> irq_enable_ff == UIAE_RST_IRQ_ENABLE)
    else $error("enable reset value wrong");

  AST_SOF_MASK: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (usb_irq && !irq_enable_ff[UIAE_BIT_SOF]) |->
    (flags.wake_cpu | flags.end_of_reset | flags.suspend))
    else $error("masked frame start interrupted");

  AST_SUSP_GATE: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (flags == uiae_events_t'{suspend: 1'b1, default: 1'b0}) |->
    usb_irq == irq_enable_ff[UIAE_BIT_SUSP])
    else $error("suspend gating wrong");

  AST_FILTER_WRITE: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    s_write_addr_reg |=>
    address_filter_enable == $past(bus.writedata[UIAE_BIT_FILTER]))
    else $error("filter enable not written");

  AST_BUS_RESET_ADDR: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    usb_bus_reset |=> func_addr_ff[6:0] == UIAE_DEFAULT_ADDR)
    else $error("address not cleared by bus reset");

  AST_ADDR_FIELD: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    s_write_addr_reg |=> func_addr_ff[6:0] == $past(bus.writedata[6:0]))
    else $error("address field not written");

  AST_ADDR_HOLD: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    s_write_addr_reg ##1 !(wr_take || usb_bus_reset) |=>
    $stable(func_addr_ff))
    else $error("address did not hold");

  AST_EP_RESERVED: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    ep_select_ff[7:4] == 4'h_0)
    else $error("reserved endpoint bits set");

  AST_EP_READ_ZERO: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    s_read_ep_select |=> avs_readdata[7:4] == 4'h_0)
    else $error("reserved endpoint bits read back");

  AST_DEFAULT_ADDR: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    !global_ctrl_ff[UIAE_BIT_ADDR_VALID] |=>
    active_function_address == UIAE_DEFAULT_ADDR)
    else $error("default address not used");

  AST_IRQ_OR: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    usb_irq == ((flags.wake_cpu && irq_enable_ff[UIAE_BIT_WAKE]) ||
                (flags.end_of_reset && irq_enable_ff[UIAE_BIT_EOR]) ||
                (flags.frame_start && irq_enable_ff[UIAE_BIT_SOF]) ||
                (flags.suspend && irq_enable_ff[UIAE_BIT_SUSP])))
    else $error("interrupt mismatch");

  AST_IRQ_NONE: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (flags.end_of_reset && !irq_enable_ff[UIAE_BIT_EOR] &&
     !flags.wake_cpu && !flags.frame_start && !flags.suspend) |-> !usb_irq)
    else $error("masked end of reset interrupted");

  AST_EP_FOLLOW: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    (wr_take && bus.address == UIAE_IDX_EP_SELECT) |=>
    endpoint_index == $past(bus.writedata[3:0]))
    else $error("endpoint index not updated");

  AST_ONE_WAIT: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    s_req_waiting |=> !req || !avs_waitrequest)
    else $error("more than one wait state");

  AST_READ_UPPER: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    avs_readdata[31:8] == 24'h_00_0000)
    else $error("upper read bits not zero");

endmodule // uiae_regs

// >>> usb_int_enable_address_epsel_tb_top.sv
// usb_int_enable_address_epsel_tb_top: self-checking bench for uiae_regs.
// assumes uiae_pkg and uiae_host_model are compiled first.
`timescale 1ns/100ps
module usb_int_enable_address_epsel_tb_top;
  import uiae_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] d;
    logic [7:0] e;
  } uiae_row_t;
  logic ref_clk;
  logic resetn;
  logic [7:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  uiae_events_t usb_event_pulse;
  logic usb_bus_reset;
  logic usb_irq;
  logic [6:0] active_function_address;
  logic address_filter_enable;
  logic [3:0] endpoint_index;
  logic [31:0] q;
  int mismatches = 0;
  int total_checks = 0;
  int bp[4] = '{0, 3, 4, 5};
  uiae_row_t rows[7] = '{
    '{UIAE_IDX_IRQ_ENABLE, 8'h_ff, 8'h_39},
    '{UIAE_IDX_IRQ_ENABLE, 8'h_00, 8'h_00},
    '{UIAE_IDX_FUNC_ADDR, 8'h_a5, 8'h_a5},
    '{UIAE_IDX_FUNC_ADDR, 8'h_7f, 8'h_7f},
    '{UIAE_IDX_EP_SELECT, 8'h_f5, 8'h_05},
    '{UIAE_IDX_EP_SELECT, 8'h_06, 8'h_06},
    '{8'h_10, 8'h_5a, 8'h_00}};

  uiae_regs dut_u (
    .ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .usb_event_pulse(usb_event_pulse), .usb_bus_reset(usb_bus_reset),
    .usb_irq(usb_irq), .active_function_address(active_function_address),
    .address_filter_enable(address_filter_enable),
    .endpoint_index(endpoint_index));

  uiae_host_model host_u (
    .ref_clk(ref_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.xfer(a, 1'b1, d, 4'h_1, q);
  endtask
  task automatic rd(input logic [7:0] a);
    host_u.xfer(a, 1'b0, 8'h_00, 4'h_1, q);
  endtask
  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // port values are looked at in the low half, once settled
  task automatic chk_bit(input logic exp);
    @(negedge ref_clk);
    total_checks++;
    if (usb_irq !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, usb_irq, exp);
    end
  endtask
  task automatic pulse(input uiae_events_t v);
    @(posedge ref_clk);
    usb_event_pulse <= v;
    @(posedge ref_clk);
    usb_event_pulse <= 4'h_0;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog, sequence
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (5000) @(posedge ref_clk);
    mismatches++;
    report_and_stop();
  end
  initial begin
    resetn = 1'b0;
    usb_event_pulse = 4'h_0;
    usb_bus_reset = 1'b0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(UIAE_IDX_IRQ_ENABLE);
    chk_reg(q, 32'h_0000_0010);
    rd(UIAE_IDX_FUNC_ADDR);
    chk_reg(q, 32'h_0000_0000);
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      chk_reg(q, {24'h_00_0000, rows[i].e});
    end
    chk_reg(32'(endpoint_index), 32'h_0000_0006);
    chk_reg(32'(address_filter_enable), 32'h_0000_0000);
    // write without byte lane 0 must not land
    host_u.xfer(UIAE_IDX_EP_SELECT, 1'b1, 8'h_03, 4'h_0, q);
    rd(UIAE_IDX_EP_SELECT);
    chk_reg(q, 32'h_0000_0006);
    for (int i = 0; i < 4; i++) begin
      wr(UIAE_IDX_IRQ_ENABLE, 8'h_01 << bp[i]);
      pulse(4'h_1 << i);
      chk_bit(1'b1);
      rd(UIAE_IDX_EVT_STATUS);
      chk_reg(q, {24'h_00_0000, 8'h_01 << bp[i]});
      wr(UIAE_IDX_IRQ_ENABLE, 8'h_00);
      chk_bit(1'b0);
      wr(UIAE_IDX_IRQ_ENABLE, ~(8'h_01 << bp[i]));
      chk_bit(1'b0);
      wr(UIAE_IDX_EVT_STATUS, 8'h_01 << bp[i]);
      wr(UIAE_IDX_IRQ_ENABLE, 8'h_01 << bp[i]);
      chk_bit(1'b0);
    end
    wr(UIAE_IDX_FUNC_ADDR, 8'h_a5);
    chk_reg(32'(active_function_address), 32'h_0000_0000);
    wr(UIAE_IDX_GLOBAL_CTRL, 8'h_01);
    // output address is registered one edge after the flag lands
    repeat (2) @(negedge ref_clk);
    chk_reg(32'(active_function_address), 32'h_0000_0025);
    chk_reg(32'(address_filter_enable), 32'h_0000_0001);
    @(posedge ref_clk);
    usb_bus_reset <= 1'b1;
    @(posedge ref_clk);
    usb_bus_reset <= 1'b0;
    rd(UIAE_IDX_FUNC_ADDR);
    chk_reg(q, 32'h_0000_0080);
    chk_reg(32'(active_function_address), 32'h_0000_0000);
    @(posedge ref_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(UIAE_IDX_IRQ_ENABLE);
    chk_reg(q, 32'h_0000_0010);
    rd(UIAE_IDX_FUNC_ADDR);
    chk_reg(q, 32'h_0000_0000);
    report_and_stop();
  end
endmodule // usb_int_enable_address_epsel_tb_top
